// ---- sft_device.sv ----
/*
 Device end of the sector file transfer sequencer: parameter queries,
 physical sector read/write by 64-byte blocks, pass-through, result fetch.
 Assumes a storage engine on the user side that moves blocks through the
 storage port of the buffer and answers each request with done or error.
*/
// Function
// - Read query takes one count, 1..255
// - Read query result: 8 bytes, count first
// - Result start LBA, four bytes, LSB first
// - Query success advances file pointer by grant
// - Host skips read when granted count zero
// - Query completion raises success status
// - Host reads with address and count returned
// - Read: 8 blocks per sector, request each
// - Host fetches block then sends read-continue
// - Write query count 0..255; 0 flushes
// - Zero write count stores length, then success
// - Write result: count first, LBA last four
// - Host skips write when granted count zero
// - Host writes with address and count returned
// - Write: 8 blocks per sector, request each
// - Host sends block, continue; device stores it
// - Device grows file length past end
// - Host should flush length when idle
// - Sector queries refused while SD active
// - Host loads CBW before pass-through
// - Pass-through return data readable by fetch
// - Storage failure ends transfer with disk error
`timescale 1ns/1ps
module sft_device
	import sft_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_srst,
	sft_link_if.dev link,
	input wire logic i_sd_active,
	input wire logic i_file_open,
	input wire logic [31:0] i_open_len,
	input wire logic [31:0] i_file_lba,
	input wire logic [31:0] i_free_sectors,
	output logic o_blk_req,
	output logic o_blk_write,
	output logic o_pass_req,
	output logic [31:0] o_blk_lba,
	output logic [2:0] o_blk_index,
	input wire logic i_blk_done,
	input wire logic i_blk_err,
	input wire logic [6:0] i_pass_len,
	output logic o_flush_req,
	output logic [31:0] o_file_len,
	input wire logic i_flush_done,
	input wire logic i_stg_we,
	input wire logic [5:0] i_stg_addr,
	input wire logic [7:0] i_stg_wdata,
	output logic [7:0] o_stg_rdata
);
	import sft_pkg::*;

	typedef struct packed {
		dev_state_type state;
		logic [7:0] cmd;
		logic [2:0] pcnt;
		logic [2:0] pneed;
		logic [31:0] plba;
		logic [7:0] pcount;
		logic hd_mode;
		logic [6:0] hd_addr;
		logic [31:0] file_ptr;
		logic [31:0] file_len;
		logic [31:0] cur_lba;
		logic [7:0] remain;
		logic [2:0] blk;
		logic is_write;
		logic [7:0] res_cnt;
		logic [31:0] res_lba;
		logic src_buf;
		logic [6:0] buf_len;
		logic [6:0] rd_ptr;
		logic [6:0] rd_idx;
		logic rd_pend;
		logic rd_valid;
		logic [7:0] rd_data;
		logic int_pulse;
		logic [7:0] int_status;
		logic blk_req;
		logic pass_req;
		logic flush_req;
	} dev_type;

	dev_type r;
	dev_type next_r;
	logic a_we;
	logic [5:0] a_addr;
	logic [7:0] a_rdata;
	logic [31:0] limit;
	logic [31:0] grant;
	logic [31:0] new_ptr;
	logic [7:0] res_byte;

	block_buffer u_buf (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_a_we(a_we),
		.i_a_addr(a_addr),
		.i_a_wdata(link.wr_data),
		.o_a_rdata(a_rdata),
		.i_b_we(i_stg_we),
		.i_b_addr(i_stg_addr),
		.i_b_wdata(i_stg_wdata),
		.o_b_rdata(o_stg_rdata)
	);

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		next_r = r;
		next_r.int_pulse = 1'b0;
		next_r.blk_req = 1'b0;
		next_r.pass_req = 1'b0;
		next_r.flush_req = 1'b0;
		next_r.rd_valid = 1'b0;
		next_r.rd_pend = link.rd_req;
		a_we = link.wr_valid && r.hd_mode && (r.hd_addr < `SFT_BLOCK_BYTES);
		a_addr = a_we ? r.hd_addr[5:0] : r.rd_ptr[5:0];
		// Unused result bytes 1..3 read as zero
		case (r.rd_idx[2:0])
			3'h0: res_byte = r.res_cnt;
			3'h4: res_byte = r.res_lba[7:0];
			3'h5: res_byte = r.res_lba[15:8];
			3'h6: res_byte = r.res_lba[23:16];
			3'h7: res_byte = r.res_lba[31:24];
			default: res_byte = 8'h00;
		endcase
		if (r.cmd == `SFT_CMD_READ_QUERY) begin
			limit = (r.file_ptr < r.file_len) ? (r.file_len - r.file_ptr) : 32'h0;
		end else begin
			limit = i_free_sectors;
		end
		grant = ({24'h0, r.pcount} < limit) ? {24'h0, r.pcount} : limit;
		new_ptr = r.file_ptr + grant;

		// Fetch path: two cycles from strobe to data, bytes past the end read zero
		if (link.rd_req) begin
			next_r.rd_idx = r.rd_ptr;
			next_r.rd_ptr = r.rd_ptr + 7'h01;
		end
		if (r.rd_pend) begin
			next_r.rd_valid = 1'b1;
			if (r.rd_idx >= r.buf_len) begin
				next_r.rd_data = 8'h00;
			end else begin
				next_r.rd_data = r.src_buf ? a_rdata : res_byte;
			end
		end
		if (a_we) begin
			next_r.hd_addr = r.hd_addr + 7'h01;
		end

		if (link.cmd_valid && link.cmd_code == `SFT_CMD_FETCH) begin
			next_r.rd_ptr = 7'h00;
		end else if (link.cmd_valid && link.cmd_code == `SFT_CMD_HOST_DATA) begin
			next_r.hd_mode = 1'b1;
			next_r.hd_addr = 7'h00;
		end

		case (r.state)
			ST_IDLE: begin
				if (i_file_open) begin
					next_r.file_ptr = 32'h0;
					next_r.file_len = i_open_len;
				end
				if (link.cmd_valid) begin
					case (link.cmd_code)
						`SFT_CMD_READ_QUERY, `SFT_CMD_WRITE_QUERY,
						`SFT_CMD_DISK_READ, `SFT_CMD_DISK_WRITE: begin
							next_r.cmd = link.cmd_code;
							next_r.hd_mode = 1'b0;
							next_r.pcnt = 3'h0;
							if (link.cmd_code == `SFT_CMD_DISK_READ ||
								link.cmd_code == `SFT_CMD_DISK_WRITE) begin
								next_r.pneed = `SFT_DISK_PARAMS;
								next_r.state = ST_PARAM;
							end else if (i_sd_active) begin
								next_r.int_pulse = 1'b1;
								next_r.int_status = `SFT_ST_CMD_ERR;
							end else begin
								next_r.pneed = `SFT_QUERY_PARAMS;
								next_r.state = ST_PARAM;
							end
						end
						`SFT_CMD_PASSTHRU: begin
							// CBW is already in the buffer
							next_r.hd_mode = 1'b0;
							next_r.pass_req = 1'b1;
							next_r.state = ST_PASS;
						end
						default: begin
						end
					endcase
				end
			end
			ST_PARAM: begin
				if (link.wr_valid) begin
					next_r.pcnt = r.pcnt + 3'h1;
					if (r.pneed == `SFT_QUERY_PARAMS || r.pcnt == `SFT_LBA_BYTES) begin
						next_r.pcount = link.wr_data;
					end else begin
						next_r.plba = {link.wr_data, r.plba[31:8]};
					end
					if (r.pcnt + 3'h1 == r.pneed) begin
						if (r.pneed == `SFT_QUERY_PARAMS) begin
							next_r.state = ST_QUERY;
						end else begin
							next_r.cur_lba = r.plba;
							next_r.remain = link.wr_data;
							next_r.blk = 3'h0;
							next_r.is_write = (r.cmd == `SFT_CMD_DISK_WRITE);
							next_r.state = ST_STEP;
						end
					end
				end
			end
			ST_QUERY: begin
				next_r.int_pulse = 1'b1;
				next_r.int_status = `SFT_ST_SUCCESS;
				next_r.src_buf = 1'b0;
				next_r.buf_len = `SFT_RESULT_BYTES;
				next_r.res_lba = i_file_lba + r.file_ptr;
				next_r.res_cnt = grant[7:0];
				next_r.state = ST_IDLE;
				if (r.pcount == 8'h00 && r.cmd == `SFT_CMD_READ_QUERY) begin
					next_r.int_status = `SFT_ST_PARAM_ERR;
				end else if (r.pcount == 8'h00) begin
					next_r.int_pulse = 1'b0;
					next_r.int_status = r.int_status;
					next_r.flush_req = 1'b1;
					next_r.state = ST_FLUSH;
				end else begin
					next_r.file_ptr = new_ptr;
					if (r.cmd == `SFT_CMD_WRITE_QUERY && new_ptr > r.file_len) begin
						next_r.file_len = new_ptr;
					end
				end
			end
			ST_FLUSH: begin
				if (i_flush_done) begin
					next_r.int_pulse = 1'b1;
					next_r.int_status = `SFT_ST_SUCCESS;
					next_r.state = ST_IDLE;
				end
			end
			ST_STEP: begin
				if (r.remain == 8'h00) begin
					next_r.int_pulse = 1'b1;
					next_r.int_status = `SFT_ST_SUCCESS;
					next_r.state = ST_IDLE;
				end else if (r.is_write) begin
					next_r.int_pulse = 1'b1;
					next_r.int_status = `SFT_ST_WRITE_REQ;
					next_r.state = ST_HOLD;
				end else begin
					next_r.blk_req = 1'b1;
					next_r.state = ST_FETCH;
				end
			end
			ST_FETCH, ST_STORE, ST_PASS: begin
				if (i_blk_err) begin
					next_r.int_pulse = 1'b1;
					next_r.int_status = `SFT_ST_DISK_ERR;
					next_r.state = ST_IDLE;
				end else if (i_blk_done) begin
					next_r.int_pulse = (r.state != ST_STORE);
					next_r.src_buf = 1'b1;
					next_r.buf_len = (r.state == ST_PASS) ? i_pass_len : `SFT_BLOCK_BYTES;
					// A store ends silently, so the status must not move without an event
					if (r.state == ST_PASS) begin
						next_r.int_status = `SFT_ST_SUCCESS;
					end else if (r.state == ST_FETCH) begin
						next_r.int_status = `SFT_ST_READ_REQ;
					end
					next_r.state = (r.state == ST_FETCH) ? ST_HOLD : ST_IDLE;
					if (r.state == ST_STORE) begin
						next_r.state = ST_STEP;
						next_r.blk = r.blk + 3'h1;
						if (r.blk == `SFT_LAST_BLOCK) begin
							next_r.remain = r.remain - 8'h01;
							next_r.cur_lba = r.cur_lba + 32'h1;
						end
					end
				end
			end
			ST_HOLD: begin
				if (link.cmd_valid && !r.is_write && link.cmd_code == `SFT_CMD_READ_GO) begin
					next_r.state = ST_STEP;
					next_r.blk = r.blk + 3'h1;
					if (r.blk == `SFT_LAST_BLOCK) begin
						next_r.remain = r.remain - 8'h01;
						next_r.cur_lba = r.cur_lba + 32'h1;
					end
				end else if (link.cmd_valid && r.is_write &&
					link.cmd_code == `SFT_CMD_WRITE_GO) begin
					next_r.hd_mode = 1'b0;
					next_r.blk_req = 1'b1;
					next_r.state = ST_STORE;
				end
			end
			default: begin
				next_r.state = ST_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			r <= '0;
			r.state <= ST_IDLE;
			r.buf_len <= `SFT_RESULT_BYTES;
		end else begin
			r <= next_r;
		end
	end

	assign link.rd_valid = r.rd_valid;
	assign link.rd_data = r.rd_data;
	assign link.int_pulse = r.int_pulse;
	assign link.int_status = r.int_status;
	assign o_blk_req = r.blk_req;
	assign o_blk_write = r.is_write;
	assign o_pass_req = r.pass_req;
	assign o_blk_lba = r.cur_lba;
	assign o_blk_index = r.blk;
	assign o_flush_req = r.flush_req;
	assign o_file_len = r.file_len;
endmodule

// ---- sft_map.svh ----
/*
 Constants for the sector file transfer sequencer: command codes,
 status codes, block geometry and parameter counts.
 Assumes inclusion by bare name from the package, the link checker and the bench.
*/
`ifndef SFT_MAP_SVH
`define SFT_MAP_SVH

// ****************************************************************
// Command codes
// ****************************************************************
`define SFT_CMD_READ_QUERY 8'h01
`define SFT_CMD_WRITE_QUERY 8'h02
`define SFT_CMD_FETCH 8'h03
`define SFT_CMD_HOST_DATA 8'h04
`define SFT_CMD_PASSTHRU 8'h05
`define SFT_CMD_DISK_READ 8'h06
`define SFT_CMD_READ_GO 8'h07
`define SFT_CMD_DISK_WRITE 8'h08
`define SFT_CMD_WRITE_GO 8'h09

// ****************************************************************
// Interrupt status codes
// ****************************************************************
`define SFT_ST_SUCCESS 8'h14
`define SFT_ST_READ_REQ 8'h1D
`define SFT_ST_WRITE_REQ 8'h1E
`define SFT_ST_DISK_ERR 8'h1F
`define SFT_ST_PARAM_ERR 8'h41
`define SFT_ST_CMD_ERR 8'h42

// ****************************************************************
// Geometry and counts
// ****************************************************************
`define SFT_BLOCK_BYTES 7'h40
`define SFT_LAST_BLOCK 3'h7
`define SFT_RESULT_BYTES 7'h08
`define SFT_QUERY_PARAMS 3'h1
`define SFT_DISK_PARAMS 3'h5
`define SFT_LBA_BYTES 3'h4

`endif

// ---- sft_pkg.sv ----
/*
 Types shared by both ends of the sector file transfer sequencer.
 Assumes sft_map.svh is on the include path.
*/
package sft_pkg;
`include "sft_map.svh"

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_PARAM = 9'h002,
		ST_QUERY = 9'h004,
		ST_FLUSH = 9'h008,
		ST_STEP = 9'h010,
		ST_FETCH = 9'h020,
		ST_HOLD = 9'h040,
		ST_STORE = 9'h080,
		ST_PASS = 9'h100
	} dev_state_type;

	typedef enum logic [7:0] {
		H_IDLE = 8'h01,
		H_QRY = 8'h02,
		H_WINT = 8'h04,
		H_RES = 8'h08,
		H_DISK = 8'h10,
		H_DRD = 8'h20,
		H_DWR = 8'h40,
		H_DONE = 8'h80
	} host_state_type;

	typedef logic [7:0] byte_type;
endpackage

// ---- sft_link_if.sv ----
/*
 Command link between the host controller and the file sequencer.
 Assumes both ends run on the same clock; valid, request and pulse signals
 are single-cycle strobes with data valid in the same cycle; int_status holds.
*/
`timescale 1ns/1ps
interface sft_link_if;
	logic cmd_valid;
	logic [7:0] cmd_code;
	logic wr_valid;
	logic [7:0] wr_data;
	logic rd_req;
	logic rd_valid;
	logic [7:0] rd_data;
	logic int_pulse;
	logic [7:0] int_status;

	modport dev(input cmd_valid, input cmd_code, input wr_valid, input wr_data,
		input rd_req, output rd_valid, output rd_data, output int_pulse,
		output int_status);
	modport host(output cmd_valid, output cmd_code, output wr_valid, output wr_data,
		output rd_req, input rd_valid, input rd_data, input int_pulse,
		input int_status);
endinterface

// ---- block_buffer.sv ----
/*
 64-byte block buffer with a link-side port and a storage-side port.
 Assumes one clock; reads are registered, one cycle of latency.
*/
`timescale 1ns/1ps
module block_buffer (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_a_we,
	input wire logic [5:0] i_a_addr,
	input wire logic [7:0] i_a_wdata,
	output logic [7:0] o_a_rdata,
	input wire logic i_b_we,
	input wire logic [5:0] i_b_addr,
	input wire logic [7:0] i_b_wdata,
	output logic [7:0] o_b_rdata
);
	logic [7:0] mem [0:63];

	// Storage port wins on a same-address collision: it lands after the link write
	always_ff @(posedge i_ref_clk) begin
		if (i_a_we) begin
			mem[i_a_addr] <= i_a_wdata;
		end
		if (i_b_we) begin
			mem[i_b_addr] <= i_b_wdata;
		end
		if (i_srst) begin
			o_a_rdata <= 8'h00;
			o_b_rdata <= 8'h00;
		end else begin
			o_a_rdata <= mem[i_a_addr];
			o_b_rdata <= mem[i_b_addr];
		end
	end
endmodule

// ---- sft_host.sv ----
/*
 Host end: runs one sector read or write sequence per start request,
 query, result fetch, then block-by-block transfer.
 Assumes the user supplies write bytes on demand and takes read bytes.
*/
`timescale 1ns/1ps
module sft_host
	import sft_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_srst,
	sft_link_if.host link,
	input wire logic i_start,
	input wire logic i_write,
	input wire logic [7:0] i_count,
	input wire logic [7:0] i_wr_data,
	output logic o_wr_take,
	output logic o_rd_valid,
	output logic [7:0] o_rd_data,
	output logic o_busy,
	output logic o_done,
	output logic o_eof,
	output logic [7:0] o_status,
	output logic [7:0] o_granted
);
	import sft_pkg::*;

	typedef struct packed {
		host_state_type state;
		logic is_write;
		logic disk_phase;
		logic [7:0] count;
		logic [7:0] granted;
		logic [31:0] lba;
		logic [7:0] cnt;
		logic waiting;
		logic cmd_valid;
		logic [7:0] cmd_code;
		logic wr_valid;
		logic [7:0] wr_data;
		logic rd_req;
		logic wr_take;
		logic rd_valid;
		logic [7:0] rd_data;
		logic busy;
		logic done;
		logic eof;
		logic [7:0] status;
	} host_type;

	host_type r;
	host_type next_r;
	logic [7:0] need;

	// ****************************************************************
	// Sequence control
	// ****************************************************************
	always_comb begin
		next_r = r;
		next_r.cmd_valid = 1'b0;
		next_r.wr_valid = 1'b0;
		next_r.rd_req = 1'b0;
		next_r.wr_take = 1'b0;
		next_r.rd_valid = 1'b0;
		next_r.done = 1'b0;
		need = (r.state == H_RES) ? 8'h08 : 8'h40;
		case (r.state)
			H_IDLE: begin
				if (i_start) begin
					next_r.is_write = i_write;
					next_r.count = i_count;
					next_r.disk_phase = 1'b0;
					next_r.busy = 1'b1;
					next_r.eof = 1'b0;
					next_r.cmd_valid = 1'b1;
					next_r.cmd_code = i_write ? `SFT_CMD_WRITE_QUERY : `SFT_CMD_READ_QUERY;
					next_r.state = H_QRY;
				end
			end
			H_QRY: begin
				next_r.wr_valid = 1'b1;
				next_r.wr_data = r.count;
				next_r.state = H_WINT;
			end
			H_WINT: begin
				if (link.int_pulse) begin
					next_r.status = link.int_status;
					next_r.cnt = 8'h00;
					next_r.waiting = 1'b0;
					next_r.cmd_valid = 1'b1;
					next_r.cmd_code = `SFT_CMD_FETCH;
					if (!r.disk_phase && link.int_status == `SFT_ST_SUCCESS) begin
						next_r.state = H_RES;
					end else if (r.disk_phase && link.int_status == `SFT_ST_READ_REQ) begin
						next_r.state = H_DRD;
					end else if (r.disk_phase && link.int_status == `SFT_ST_WRITE_REQ) begin
						next_r.cmd_code = `SFT_CMD_HOST_DATA;
						next_r.state = H_DWR;
					end else begin
						next_r.cmd_valid = 1'b0;
						next_r.state = H_DONE;
					end
				end
			end
			H_RES, H_DRD: begin
				if (!r.waiting && r.cnt < need) begin
					next_r.rd_req = 1'b1;
					next_r.waiting = 1'b1;
				end
				if (link.rd_valid) begin
					next_r.waiting = 1'b0;
					next_r.cnt = r.cnt + 8'h01;
					if (r.state == H_DRD) begin
						next_r.rd_valid = 1'b1;
						next_r.rd_data = link.rd_data;
					end else if (r.cnt == 8'h00) begin
						next_r.granted = link.rd_data;
					end else if (r.cnt >= 8'h04) begin
						next_r.lba = {link.rd_data, r.lba[31:8]};
					end
				end
				if (r.cnt == need) begin
					next_r.cnt = 8'h00;
					next_r.cmd_valid = 1'b1;
					if (r.state == H_DRD) begin
						next_r.cmd_code = `SFT_CMD_READ_GO;
						next_r.state = H_WINT;
					end else if (r.granted == 8'h00) begin
						next_r.cmd_valid = 1'b0;
						next_r.eof = 1'b1;
						next_r.state = H_DONE;
					end else begin
						next_r.cmd_code = r.is_write ? `SFT_CMD_DISK_WRITE
							: `SFT_CMD_DISK_READ;
						next_r.disk_phase = 1'b1;
						next_r.state = H_DISK;
					end
				end
			end
			H_DISK: begin
				next_r.wr_valid = 1'b1;
				next_r.cnt = r.cnt + 8'h01;
				if (r.cnt == 8'h04) begin
					next_r.wr_data = r.granted;
					next_r.state = H_WINT;
				end else begin
					next_r.wr_data = r.lba[8 * r.cnt[1:0] +: 8];
				end
			end
			H_DWR: begin
				// One byte every other cycle so the user can advance on the take pulse
				next_r.cnt = r.cnt + 8'h01;
				if (r.cnt == 8'h80) begin
					next_r.cmd_valid = 1'b1;
					next_r.cmd_code = `SFT_CMD_WRITE_GO;
					next_r.cnt = 8'h00;
					next_r.state = H_WINT;
				end else if (!r.cnt[0]) begin
					next_r.wr_valid = 1'b1;
					next_r.wr_data = i_wr_data;
					next_r.wr_take = 1'b1;
				end
			end
			H_DONE: begin
				next_r.done = 1'b1;
				next_r.busy = 1'b0;
				next_r.state = H_IDLE;
			end
			default: begin
				next_r.state = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			r <= '0;
			r.state <= H_IDLE;
		end else begin
			r <= next_r;
		end
	end

	assign link.cmd_valid = r.cmd_valid;
	assign link.cmd_code = r.cmd_code;
	assign link.wr_valid = r.wr_valid;
	assign link.wr_data = r.wr_data;
	assign link.rd_req = r.rd_req;
	assign o_wr_take = r.wr_take;
	assign o_rd_valid = r.rd_valid;
	assign o_rd_data = r.rd_data;
	assign o_busy = r.busy;
	assign o_done = r.done;
	assign o_eof = r.eof;
	assign o_status = r.status;
	assign o_granted = r.granted;
endmodule

// ---- sft_link_sva.sv ----
/*
 Checker for the command link of the sector file sequencer.
 Assumes both ends share one clock and one synchronous reset.
*/
`timescale 1ns/1ps
`include "sft_map.svh"
module sft_link_sva (
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	input wire logic rd_req,
	input wire logic rd_valid,
	input wire logic int_pulse,
	input wire logic [7:0] int_status
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	// ********
	// Tally of block requests against the sector count of a disk phase
	// ********
	logic [2:0] pidx;
	logic [10:0] need, seen;
	logic disk, rq, wq;
	always_ff @(posedge i_ref_clk) begin
		rq <= !i_srst && cmd_valid && cmd_code == `SFT_CMD_READ_QUERY;
		wq <= !i_srst && cmd_valid && cmd_code == `SFT_CMD_WRITE_QUERY;
		if (i_srst) begin
			pidx <= 3'h0;
			need <= 11'h000;
			seen <= 11'h000;
			disk <= 1'b0;
		end else if (cmd_valid && cmd_code inside {`SFT_CMD_DISK_READ, `SFT_CMD_DISK_WRITE}) begin
			pidx <= 3'h1;
			seen <= 11'h000;
			disk <= 1'b1;
		end else begin
			if (wr_valid && pidx != 3'h0)
				pidx <= (pidx == 3'h5) ? 3'h0 : pidx + 3'h1;
			if (wr_valid && pidx == 3'h5)
				need <= {wr_data, 3'h0};
			if (int_pulse && int_status inside {`SFT_ST_READ_REQ, `SFT_ST_WRITE_REQ})
				seen <= seen + 11'h001;
			if (int_pulse && int_status inside {`SFT_ST_SUCCESS, `SFT_ST_DISK_ERR})
				disk <= 1'b0;
		end
	end
	// ********
	// Link relations
	// ********
	a_fetch_two_later: assert property (rd_req |-> ##2 rd_valid)
		else $error("fetch byte not returned two cycles after request");
	a_fetch_has_cause: assert property (rd_valid |-> $past(rd_req, 2))
		else $error("fetch byte without request");
	a_status_with_pulse: assert property ($changed(int_status) |-> int_pulse)
		else $error("status changed without event");
	a_pulse_one_cycle: assert property (int_pulse |=> !int_pulse)
		else $error("event pulse longer than one cycle");
	a_query_answer: assert property (rq && wr_valid |-> ##[0:2] int_pulse)
		else $error("read query not answered");
	a_flush_then_ok: assert property (wq && wr_valid && wr_data == 8'h00 |->
		##[3:40] int_pulse && int_status == `SFT_ST_SUCCESS) else $error("flush not answered");
	a_read_go_after: assert property (cmd_valid && cmd_code == `SFT_CMD_READ_GO |->
		int_status == `SFT_ST_READ_REQ) else $error("read continue without request");
	a_write_go_after: assert property (cmd_valid && cmd_code == `SFT_CMD_WRITE_GO |->
		int_status == `SFT_ST_WRITE_REQ) else $error("write continue without request");
	a_disk_after_ok: assert property (cmd_valid && cmd_code inside
		{`SFT_CMD_DISK_READ, `SFT_CMD_DISK_WRITE} |-> int_status == `SFT_ST_SUCCESS)
		else $error("disk phase without successful query");
	a_blocks_per_sector: assert property (disk && int_pulse &&
		int_status == `SFT_ST_SUCCESS |-> seen == need) else $error("block count wrong");
	c_disk_done: cover property (disk && int_pulse && int_status == `SFT_ST_SUCCESS);
	c_disk_err: cover property (int_pulse && int_status == `SFT_ST_DISK_ERR);
	c_flush: cover property (wq && wr_valid && wr_data == 8'h00);
endmodule

// ---- sector_file_transfer_sequencer_tb_top.sv ----
/*
 Bench: host and device ends on one link, storage and flush model
 behind the device.
 Assumes sft_map.svh is on the include path.
*/
`timescale 1ns/1ps
`include "sft_map.svh"
module sector_file_transfer_sequencer_tb_top;
	import sft_pkg::*;
	logic i_ref_clk = 1'b0;
	logic i_srst = 1'b1;
	logic start = 1'b0, wr = 1'b0, sd = 1'b0, fopen = 1'b0;
	logic bdone = 1'b0, berr = 1'b0, fdone = 1'b0, swe = 1'b0;
	logic wtake, hrv, done, eof, breq, bwr, freq, busy;
	logic [2:0] bidx;
	logic [5:0] saddr = 6'h00;
	logic [31:0] blba, flen, first_lba, exp_len = 32'h00000004;
	logic [31:0] free = 32'h0000000A;
	logic [15:0] rdk = 16'h0000, wcnt = 16'h0000;
	byte_type cnt = 8'h00, sdata = 8'h00, hrd, status, granted, srd;
	int err_count = 0, num_checks = 0, nblk = 0, fail_at = -1, flushes = 0;
	localparam logic [31:0] BASE = 32'h00012340;
	always #20 i_ref_clk = ~i_ref_clk;
	sft_link_if sft_link_if_i ();
	sft_host sft_host_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .link(sft_link_if_i.host),
		.i_start(start), .i_write(wr), .i_count(cnt), .i_wr_data(wcnt[7:0]), .o_wr_take(wtake),
		.o_rd_valid(hrv), .o_rd_data(hrd), .o_busy(busy), .o_done(done), .o_eof(eof),
		.o_status(status), .o_granted(granted));
	sft_device sft_device_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .link(sft_link_if_i.dev),
		.i_sd_active(sd), .i_file_open(fopen), .i_open_len(32'h00000003), .i_file_lba(BASE),
		.i_free_sectors(free), .o_blk_req(breq), .o_blk_write(bwr), .o_pass_req(),
		.o_blk_lba(blba), .o_blk_index(bidx), .i_blk_done(bdone), .i_blk_err(berr),
		.i_pass_len(7'h40), .o_flush_req(freq), .o_file_len(flen), .i_flush_done(fdone),
		.i_stg_we(swe), .i_stg_addr(saddr), .i_stg_wdata(sdata), .o_stg_rdata(srd));
	sft_link_sva sft_link_sva_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
		.cmd_valid(sft_link_if_i.cmd_valid), .cmd_code(sft_link_if_i.cmd_code),
		.wr_valid(sft_link_if_i.wr_valid), .wr_data(sft_link_if_i.wr_data),
		.rd_req(sft_link_if_i.rd_req), .rd_valid(sft_link_if_i.rd_valid),
		.int_pulse(sft_link_if_i.int_pulse), .int_status(sft_link_if_i.int_status));
	// ********
	// Shared checks and ending
	// ********
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic close_out;
		if (err_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ********
	// Storage and flush model; a fetched block carries a per-block pattern
	// ********
	always @(posedge i_ref_clk) begin
		#1;
		if (hrv === 1'b1) begin
			chk("read byte", {2'b00, rdk[5:0]} ^ {rdk[8:6], 5'h00}, {24'h0, hrd});
			rdk <= rdk + 16'h0001;
		end
		if (wtake === 1'b1)
			wcnt <= wcnt + 16'h0001;
	end
	always begin
		@(posedge i_ref_clk);
		#1;
		if (breq === 1'b1) begin
			if (nblk == 0)
				first_lba = blba;
			for (int a = 0; a < 64; a++) begin
				swe <= !bwr;
				saddr <= a[5:0];
				sdata <= {2'b00, a[5:0]} ^ {bidx, 5'h00};
				@(posedge i_ref_clk);
				#1;
				if (bwr === 1'b1)
					chk("stored byte", {nblk[1:0], a[5:0]}, {24'h0, srd});
			end
			swe <= 1'b0;
			repeat (2) @(posedge i_ref_clk);
			berr <= (nblk == fail_at);
			bdone <= (nblk != fail_at);
			@(posedge i_ref_clk);
			berr <= 1'b0;
			bdone <= 1'b0;
			nblk++;
		end else if (freq === 1'b1) begin
			chk("file length", exp_len, flen);
			flushes++;
			repeat (3) @(posedge i_ref_clk);
			fdone <= 1'b1;
			@(posedge i_ref_clk);
			fdone <= 1'b0;
		end
	end
	// ********
	// Scenarios
	// ********
	task automatic run(input logic w, input byte_type c);
		int n;
		repeat (2) @(posedge i_ref_clk);
		nblk = 0;
		first_lba = 32'hFFFFFFFF;
		rdk <= 16'h0000;
		wcnt <= 16'h0000;
		wr <= w;
		cnt <= c;
		start <= 1'b1;
		@(posedge i_ref_clk);
		start <= 1'b0;
		#1;
		chk("busy", 1, busy);
		for (n = 0; n < 30000 && done !== 1'b1; n++) begin
			@(posedge i_ref_clk);
			#1;
		end
		if (n == 30000) begin
			chk("done wait", 1, 0);
			close_out();
		end
		chk("busy", 0, busy);
	endtask
	task automatic expect_end(input byte_type g, input byte_type st, input int n);
		chk("granted", g, granted);
		chk("status", st, status);
		chk("blocks", n, nblk);
	endtask
	task automatic t_read_two;
		run(1'b0, 8'h02);
		expect_end(8'h02, `SFT_ST_SUCCESS, 16);
		chk("start lba", BASE, first_lba);
		chk("bytes read", 1024, rdk);
	endtask
	task automatic t_read_tail;
		run(1'b0, 8'h05);
		expect_end(8'h01, `SFT_ST_SUCCESS, 8);
		chk("start lba", BASE + 32'h2, first_lba);
	endtask
	task automatic t_read_end;
		run(1'b0, 8'h01);
		expect_end(8'h00, `SFT_ST_SUCCESS, 0);
		chk("eof", 1, eof);
	endtask
	task automatic t_read_zero;
		run(1'b0, 8'h00);
		chk("status", `SFT_ST_PARAM_ERR, status);
	endtask
	task automatic t_write_one;
		run(1'b1, 8'h01);
		expect_end(8'h01, `SFT_ST_SUCCESS, 8);
		chk("start lba", BASE + 32'h3, first_lba);
	endtask
	task automatic t_flush;
		run(1'b1, 8'h00);
		chk("status", `SFT_ST_SUCCESS, status);
		chk("flushes", 1, flushes);
		chk("blocks", 0, nblk);
	endtask
	task automatic t_disk_err;
		fail_at = 2;
		run(1'b1, 8'h01);
		expect_end(8'h01, `SFT_ST_DISK_ERR, 3);
		fail_at = -1;
	endtask
	task automatic t_disk_full;
		free <= 32'h00000000;
		run(1'b1, 8'h03);
		expect_end(8'h00, `SFT_ST_SUCCESS, 0);
		chk("eof", 1, eof);
	endtask
	task automatic t_sd;
		sd <= 1'b1;
		run(1'b0, 8'h01);
		chk("status", `SFT_ST_CMD_ERR, status);
		chk("blocks", 0, nblk);
		sd <= 1'b0;
	endtask
	initial begin
		repeat (2) @(posedge i_ref_clk);
		i_srst <= 1'b0;
		fopen <= 1'b1;
		@(posedge i_ref_clk);
		fopen <= 1'b0;
		t_read_two();
		t_read_tail();
		t_read_end();
		t_read_zero();
		t_write_one();
		t_flush();
		t_disk_err();
		t_disk_full();
		t_sd();
		close_out();
	end
endmodule
